// *** rtl/spf_pkg.sv ***
package spf_pkg;
    // zero in every configuration field selects the power-on default
    localparam int unsigned SPF_CLK_HZ = 100_000_000;
    localparam int unsigned SPF_BAUD_DEFAULT = 9600;
    localparam int unsigned SPF_DIV_9600 = SPF_CLK_HZ / SPF_BAUD_DEFAULT;
    localparam int SPF_DIV_W = 16;
    localparam int SPF_DATA_BITS = 8;
    localparam logic [2:0] SPF_LAST_BIT = 3'h7;
    localparam logic [7:0] SPF_XON = 8'h11;
    localparam logic [7:0] SPF_XOFF = 8'h13;
    localparam logic [1:0] SPF_PAR_NONE = 2'h0;
    localparam logic [1:0] SPF_PAR_EVEN = 2'h1;
    localparam logic [1:0] SPF_PAR_ODD = 2'h2;
    localparam logic [2:0] SPF_BAUD_9600 = 3'h0;
    localparam logic [2:0] SPF_BAUD_19200 = 3'h1;
    localparam logic [2:0] SPF_BAUD_38400 = 3'h2;
    localparam logic [2:0] SPF_BAUD_57600 = 3'h3;
    localparam logic [2:0] SPF_BAUD_115200 = 3'h4;
    localparam logic SPF_LINE_IDLE = 1'b1;

    typedef struct packed {
        logic [2:0] baud_sel;
        logic [1:0] parity;
        logic flow_off;
        logic half_duplex;
        logic addr_en;
        logic [7:0] bus_addr;
    } spf_cfg_t;

    typedef enum logic [2:0] {
        SPF_ST_IDLE = 3'h0,
        SPF_ST_START = 3'h1,
        SPF_ST_DATA = 3'h3,
        SPF_ST_PAR = 3'h6,
        SPF_ST_STOP = 3'h2
    } spf_bit_st_t;

    function automatic logic [SPF_DIV_W-1:0] spf_bit_div(
        input logic [2:0] sel,
        input int unsigned d9600
    );
        int unsigned q;
        begin
            q = d9600;
            case (sel)
                SPF_BAUD_19200: q = d9600 / 2;
                SPF_BAUD_38400: q = d9600 / 4;
                SPF_BAUD_57600: q = d9600 / 6;
                SPF_BAUD_115200: q = d9600 / 12;
                default: q = d9600;
            endcase
            return q[SPF_DIV_W-1:0];
        end
    endfunction : spf_bit_div
endpackage : spf_pkg

// *** rtl/spf_buf.sv ***
`timescale 1ns/1ps
module spf_buf #(
    parameter int W = spf_pkg::SPF_DATA_BITS // word width
) (
    input wire logic sys_clk_i, // clock
    input wire logic arst_n_i, // async reset, low
    input wire logic ce_i, // clock enable
    input wire logic in_valid_i, // word offered
    input wire logic [W-1:0] in_data_i, // word in
    output logic in_ready_o, // room for a word
    output logic out_valid_o, // head word valid
    output logic [W-1:0] out_data_o, // head word
    input wire logic out_ready_i // head taken
);
    import spf_pkg::*;

    logic spare_v_r;
    logic [W-1:0] spare_d_r;
    logic push;
    logic pop;

    // ready is a flop of its own so the port sees a registered output
    assign push = in_valid_i && !spare_v_r;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_valid_o <= 1'b0;
            out_data_o <= '0;
            spare_v_r <= 1'b0;
            spare_d_r <= '0;
            in_ready_o <= 1'b1;
        end else if (ce_i) begin
            if (pop && spare_v_r) begin
                out_data_o <= spare_d_r;
                spare_v_r <= 1'b0;
                in_ready_o <= 1'b1;
            end else if (pop || (push && !out_valid_o)) begin
                out_valid_o <= push;
                out_data_o <= in_data_i;
            end else if (push) begin
                spare_v_r <= 1'b1;
                in_ready_o <= 1'b0;
                spare_d_r <= in_data_i;
            end
        end
    end

    // a stalled drain keeps the second word
    property p_buf_keep;
        @(posedge sys_clk_i) disable iff (!arst_n_i)
        (ce_i && spare_v_r && !out_ready_i) |=> (spare_v_r && out_valid_o);
    endproperty
    a_buf_keep: assert property (p_buf_keep)
        else $error("buffer lost a word");
endmodule : spf_buf

// *** rtl/spf_serial_port.sv ***
`timescale 1ns/1ps
// Behaviour
// - in full duplex, transmit and receive run at once, independently
// - a side that cannot accept sends XOFF; peer stops on XOFF
// - when able again send XON; stopped sender resumes where it stopped
// - every character is 8 data bits, a parity bit when enabled, then 1 stop bit
// - defaults are 9600 baud, no parity, XON/XOFF enabled
// - baud rate, flow protocol and parity are set per port
// - flow control only in-band on data lines, no handshake lines
// - two-wire mode is half duplex: one driver at a time
// - second port goes half duplex only when that option is selected
// - on a shared bus the device answers only when addressed
// - a bridged port behaves exactly like the plain serial port
module spf_serial_port #(
    parameter bit SECOND_PORT = 1'b1, // half duplex allowed on this port
    parameter int unsigned DIV_9600 = spf_pkg::SPF_DIV_9600 // cycles per bit
) (
    input wire logic sys_clk_i, // 100 MHz clock
    input wire logic arst_n_i, // async reset, low
    input wire logic ce_i, // clock enable, low freezes
    input wire spf_pkg::spf_cfg_t cfg_i, // port configuration
    input wire logic rxd_i, // serial receive line
    output logic txd_o, // serial transmit line
    output logic txd_oe_o, // line driver enable
    input wire logic [7:0] tx_data_i, // character to send
    input wire logic tx_valid_i, // character offered
    output logic tx_ready_o, // character accepted
    output logic [7:0] rx_data_o, // received character
    output logic rx_valid_o, // received character valid
    input wire logic rx_ready_i, // received character taken
    output logic rx_par_err_o, // parity error pulse
    output logic rx_frm_err_o, // stop bit error pulse
    output logic rx_ovr_err_o, // overrun pulse
    output logic tx_paused_o, // peer sent XOFF
    output logic addressed_o // bus address matched
);
    import spf_pkg::*;

    logic hd_on;
    logic flow_on;
    logic par_on;
    logic par_odd;
    logic [SPF_DIV_W-1:0] div;
    logic [SPF_DIV_W-1:0] div_m1;
    logic [SPF_DIV_W-1:0] half_div;

    assign hd_on = SECOND_PORT && cfg_i.half_duplex;
    assign flow_on = !cfg_i.flow_off;
    assign par_on = cfg_i.parity != SPF_PAR_NONE;
    assign par_odd = cfg_i.parity == SPF_PAR_ODD;
    assign div = spf_bit_div(cfg_i.baud_sel, DIV_9600);
    assign div_m1 = div - 16'h0001;
    assign half_div = {1'b0, div[SPF_DIV_W-1:1]};

    // receive path
    spf_bit_st_t rx_st_r, rx_st_nxt;
    logic [SPF_DIV_W-1:0] rx_cnt_r, rx_cnt_nxt;
    logic [2:0] rx_bit_r, rx_bit_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    logic rx_perr_r, rx_perr_nxt;
    logic rx_tick, rx_done, rx_ferr, rx_par_bad;
    logic rx_is_xon, rx_is_xoff, rx_is_addr, rx_push;
    logic rxb_ready;
    logic tx_busy;

    assign rx_tick = rx_cnt_r == '0;
    assign rx_done = rx_st_r == SPF_ST_STOP && rx_tick && rxd_i;
    assign rx_ferr = rx_st_r == SPF_ST_STOP && rx_tick && !rxd_i;
    assign rx_par_bad = rxd_i != (^rx_sh_r ^ par_odd);
    // with flow control on, flow characters never reach the user side
    assign rx_is_xon = rx_done && flow_on && rx_sh_r == SPF_XON;
    assign rx_is_xoff = rx_done && flow_on && rx_sh_r == SPF_XOFF;
    assign rx_is_addr = rx_done && hd_on && cfg_i.addr_en
        && rx_sh_r == cfg_i.bus_addr;
    assign rx_push = rx_done && !rx_is_xon && !rx_is_xoff && !rx_is_addr;

    always_comb begin
        rx_st_nxt = rx_st_r;
        rx_cnt_nxt = rx_cnt_r - 16'h0001;
        rx_bit_nxt = rx_bit_r;
        rx_sh_nxt = rx_sh_r;
        rx_perr_nxt = rx_perr_r;
        case (rx_st_r)
            SPF_ST_IDLE: begin
                rx_cnt_nxt = half_div;
                rx_perr_nxt = 1'b0;
                // own echo is ignored while this end drives the bus
                if (!rxd_i && !(hd_on && tx_busy)) begin
                    rx_st_nxt = SPF_ST_START;
                end
            end
            SPF_ST_START: begin
                if (rx_tick) begin
                    rx_cnt_nxt = div_m1;
                    rx_bit_nxt = 3'h0;
                    rx_st_nxt = rxd_i ? SPF_ST_IDLE : SPF_ST_DATA;
                end
            end
            SPF_ST_DATA: begin
                if (rx_tick) begin
                    rx_cnt_nxt = div_m1;
                    rx_sh_nxt = {rxd_i, rx_sh_r[7:1]};
                    rx_bit_nxt = rx_bit_r + 3'h1;
                    if (rx_bit_r == SPF_LAST_BIT) begin
                        rx_st_nxt = par_on ? SPF_ST_PAR : SPF_ST_STOP;
                    end
                end
            end
            SPF_ST_PAR: begin
                if (rx_tick) begin
                    rx_cnt_nxt = div_m1;
                    rx_perr_nxt = rx_par_bad;
                    rx_st_nxt = SPF_ST_STOP;
                end
            end
            SPF_ST_STOP: begin
                if (rx_tick) begin
                    rx_st_nxt = SPF_ST_IDLE;
                end
            end
            default: rx_st_nxt = SPF_ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_st_r <= SPF_ST_IDLE;
            rx_cnt_r <= '0;
            rx_bit_r <= 3'h0;
            rx_sh_r <= 8'h00;
            rx_perr_r <= 1'b0;
            rx_par_err_o <= 1'b0;
            rx_frm_err_o <= 1'b0;
            rx_ovr_err_o <= 1'b0;
        end else if (ce_i) begin
            rx_st_r <= rx_st_nxt;
            rx_cnt_r <= rx_cnt_nxt;
            rx_bit_r <= rx_bit_nxt;
            rx_sh_r <= rx_sh_nxt;
            rx_perr_r <= rx_perr_nxt;
            rx_par_err_o <= rx_done && rx_perr_r;
            rx_frm_err_o <= rx_ferr;
            rx_ovr_err_o <= rx_push && !rxb_ready;
        end
    end

    // the same byte stream serves a bridged port unchanged
    spf_buf #(.W(SPF_DATA_BITS)) u_rx_buf (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .in_valid_i(rx_push),
        .in_data_i(rx_sh_r),
        .in_ready_o(rxb_ready),
        .out_valid_o(rx_valid_o),
        .out_data_o(rx_data_o),
        .out_ready_i(rx_ready_i)
    );

    // transmit path
    spf_bit_st_t tx_st_r, tx_st_nxt;
    logic [SPF_DIV_W-1:0] tx_cnt_r, tx_cnt_nxt;
    logic [2:0] tx_bit_r, tx_bit_nxt;
    logic [7:0] tx_sh_r, tx_sh_nxt;
    logic tx_par_r, tx_par_nxt;
    logic tx_pay_r, tx_pay_nxt;
    logic tx_tick, xoff_need, ctl_xoff, ctl_xon, permit;
    logic start_ctl, start_pay, release_bus;
    logic [7:0] load_byte;
    logic txb_valid;
    logic [7:0] txb_data;
    logic xoff_sent_r, addressed_r, tx_paused_r;
    logic txd_nxt;

    assign tx_tick = tx_cnt_r == '0;
    assign tx_busy = tx_st_r != SPF_ST_IDLE;
    // one occupied entry leaves room for a character already in flight
    assign xoff_need = flow_on && rx_valid_o;
    assign ctl_xoff = xoff_need && !xoff_sent_r;
    assign ctl_xon = flow_on && !xoff_need && xoff_sent_r;
    assign permit = !hd_on || !cfg_i.addr_en || addressed_r;
    assign start_ctl = !tx_busy && (ctl_xoff || ctl_xon) && permit;
    assign start_pay = !tx_busy && !(ctl_xoff || ctl_xon) && permit
        && txb_valid && !(flow_on && tx_paused_r);
    assign load_byte = ctl_xoff ? SPF_XOFF : (ctl_xon ? SPF_XON : txb_data);
    assign release_bus = tx_st_r == SPF_ST_STOP && tx_tick && tx_pay_r
        && !txb_valid;

    spf_buf #(.W(SPF_DATA_BITS)) u_tx_buf (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(ce_i),
        .in_valid_i(tx_valid_i),
        .in_data_i(tx_data_i),
        .in_ready_o(tx_ready_o),
        .out_valid_o(txb_valid),
        .out_data_o(txb_data),
        .out_ready_i(start_pay)
    );

    always_comb begin
        tx_st_nxt = tx_st_r;
        tx_cnt_nxt = tx_cnt_r - 16'h0001;
        tx_bit_nxt = tx_bit_r;
        tx_sh_nxt = tx_sh_r;
        tx_par_nxt = tx_par_r;
        tx_pay_nxt = tx_pay_r;
        case (tx_st_r)
            SPF_ST_IDLE: begin
                tx_cnt_nxt = div_m1;
                if (start_ctl || start_pay) begin
                    tx_st_nxt = SPF_ST_START;
                    tx_sh_nxt = load_byte;
                    tx_par_nxt = ^load_byte ^ par_odd;
                    tx_pay_nxt = start_pay;
                end
            end
            SPF_ST_START: begin
                if (tx_tick) begin
                    tx_cnt_nxt = div_m1;
                    tx_bit_nxt = 3'h0;
                    tx_st_nxt = SPF_ST_DATA;
                end
            end
            SPF_ST_DATA: begin
                if (tx_tick) begin
                    tx_cnt_nxt = div_m1;
                    tx_sh_nxt = {1'b0, tx_sh_r[7:1]};
                    tx_bit_nxt = tx_bit_r + 3'h1;
                    if (tx_bit_r == SPF_LAST_BIT) begin
                        tx_st_nxt = par_on ? SPF_ST_PAR : SPF_ST_STOP;
                    end
                end
            end
            SPF_ST_PAR: begin
                if (tx_tick) begin
                    tx_cnt_nxt = div_m1;
                    tx_st_nxt = SPF_ST_STOP;
                end
            end
            SPF_ST_STOP: begin
                if (tx_tick) begin
                    tx_st_nxt = SPF_ST_IDLE;
                end
            end
            default: tx_st_nxt = SPF_ST_IDLE;
        endcase
    end

    assign txd_nxt = tx_st_nxt == SPF_ST_START ? 1'b0 :
        tx_st_nxt == SPF_ST_DATA ? tx_sh_nxt[0] :
        tx_st_nxt == SPF_ST_PAR ? tx_par_nxt : SPF_LINE_IDLE;

    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_st_r <= SPF_ST_IDLE;
            tx_cnt_r <= '0;
            tx_bit_r <= 3'h0;
            tx_sh_r <= 8'h00;
            tx_par_r <= 1'b0;
            tx_pay_r <= 1'b0;
            txd_o <= SPF_LINE_IDLE;
            txd_oe_o <= 1'b0;
        end else if (ce_i) begin
            tx_st_r <= tx_st_nxt;
            tx_cnt_r <= tx_cnt_nxt;
            tx_bit_r <= tx_bit_nxt;
            tx_sh_r <= tx_sh_nxt;
            tx_par_r <= tx_par_nxt;
            tx_pay_r <= tx_pay_nxt;
            txd_o <= txd_nxt;
            txd_oe_o <= !hd_on || tx_st_nxt != SPF_ST_IDLE;
        end
    end

    // flow and address state; a set in the clearing cycle wins
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            xoff_sent_r <= 1'b0;
            tx_paused_r <= 1'b0;
            addressed_r <= 1'b0;
        end else if (ce_i) begin
            if (start_ctl) begin
                xoff_sent_r <= ctl_xoff;
            end else if (!flow_on) begin
                xoff_sent_r <= 1'b0;
            end
            if (!flow_on) begin
                tx_paused_r <= 1'b0;
            end else if (rx_is_xoff) begin
                tx_paused_r <= 1'b1;
            end else if (rx_is_xon) begin
                tx_paused_r <= 1'b0;
            end
            if (!hd_on || !cfg_i.addr_en) begin
                addressed_r <= 1'b0;
            end else if (rx_is_addr) begin
                addressed_r <= 1'b1;
            end else if (release_bus) begin
                addressed_r <= 1'b0;
            end
        end
    end

    assign tx_paused_o = tx_paused_r;
    assign addressed_o = addressed_r;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!arst_n_i);

    property p_start_low;
        tx_st_r == SPF_ST_START |-> !txd_o;
    endproperty
    a_start_low: assert property (p_start_low)
        else $error("start not low");
    property p_stop_high;
        tx_st_r == SPF_ST_STOP |-> txd_o;
    endproperty
    a_stop_high: assert property (p_stop_high)
        else $error("stop not high");
    property p_eight_bits;
        (ce_i && tx_st_r == SPF_ST_DATA && tx_tick && tx_bit_r == 3'h7)
            |=> tx_st_r == (par_on ? SPF_ST_PAR : SPF_ST_STOP);
    endproperty
    a_eight_bits: assert property (p_eight_bits)
        else $error("bit count");
    property p_xoff_pauses;
        (ce_i && rx_is_xoff) |=> tx_paused_o;
    endproperty
    a_xoff_pauses: assert property (p_xoff_pauses)
        else $error("no pause");
    property p_xon_resumes;
        (ce_i && rx_is_xon) |=> !tx_paused_o;
    endproperty
    a_xon_resumes: assert property (p_xon_resumes)
        else $error("no resume");
    property p_paused_quiet;
        (ce_i && flow_on && tx_paused_r && !tx_busy) |=> (!tx_busy
            || tx_sh_r == SPF_XON || tx_sh_r == SPF_XOFF);
    endproperty
    a_paused_quiet: assert property (p_paused_quiet)
        else $error("sent paused");
    property p_xoff_sent;
        (ce_i && ctl_xoff && permit && !tx_busy)
            |=> (tx_st_r == SPF_ST_START && tx_sh_r == SPF_XOFF);
    endproperty
    a_xoff_sent: assert property (p_xoff_sent)
        else $error("xoff not sent");
    property p_flow_eaten;
        (rx_done && flow_on && (rx_sh_r == SPF_XON || rx_sh_r == SPF_XOFF))
            |-> !rx_push;
    endproperty
    a_flow_eaten: assert property (p_flow_eaten)
        else $error("flow passed");
    property p_oe_busy;
        tx_busy |-> txd_oe_o;
    endproperty
    a_oe_busy: assert property (p_oe_busy)
        else $error("oe low in frame");
    property p_hd_release;
        (hd_on && $past(hd_on) && !tx_busy && $past(ce_i)) |-> !txd_oe_o;
    endproperty
    a_hd_release: assert property (p_hd_release)
        else $error("bus held");
    property p_addr_gate;
        (ce_i && hd_on && cfg_i.addr_en && !addressed_r && !tx_busy)
            |=> !tx_busy;
    endproperty
    a_addr_gate: assert property (p_addr_gate)
        else $error("unaddressed tx");
    property p_duplex;
        (ce_i && !hd_on && rx_st_r == SPF_ST_IDLE && !rxd_i)
            |=> rx_st_r == SPF_ST_START;
    endproperty
    a_duplex: assert property (p_duplex)
        else $error("rx blocked");
endmodule : spf_serial_port

// *** tb/spf_host.sv ***
`timescale 1ns/1ps
module spf_host (
    input wire logic sys_clk_i, // bench clock
    input wire logic txd_i, // device transmit line
    input wire logic txd_oe_i, // device driver enable
    output logic rxd_o // device receive line
);
    int div = 24;
    logic [1:0] par = 2'h0;
    logic [7:0] rx_q[$];
    int n_frm = 0;
    logic [7:0] sh;
    logic line;

    // a released bus rests high through its fail-safe bias
    assign line = txd_oe_i ? txd_i : 1'b1;
    initial rxd_o = 1'b1;

    function automatic logic par_bit(input logic [7:0] d);
        return (par == 2'h2) ? ~^d : ^d;
    endfunction : par_bit

    // start, 8 data lsb first, optional parity, 1 stop
    task automatic send(input logic [7:0] d);
        logic [10:0] f;
        int n;
        n = (par == 2'h0) ? 10 : 11;
        f = (par == 2'h0) ? {2'b11, d, 1'b0} : {1'b1, par_bit(d), d, 1'b0};
        for (int i = 0; i < n; i++) begin
            @(negedge sys_clk_i);
            rxd_o = f[i];
            repeat (div - 1) @(negedge sys_clk_i);
        end
    endtask : send

    // samples mid-bit; parity or stop faults are counted
    initial begin
        forever begin
            @(posedge sys_clk_i);
            if (line == 1'b0) begin
                repeat (div / 2) @(posedge sys_clk_i);
                if (line == 1'b0) begin
                    for (int i = 0; i < 8; i++) begin
                        repeat (div) @(posedge sys_clk_i);
                        sh[i] = line;
                    end
                    if (par != 2'h0) begin
                        repeat (div) @(posedge sys_clk_i);
                        if (line !== par_bit(sh)) n_frm++;
                    end
                    repeat (div) @(posedge sys_clk_i);
                    if (line !== 1'b1) n_frm++;
                    rx_q.push_back(sh);
                end
            end
        end
    end
endmodule : spf_host

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import spf_pkg::*;
    // the fastest rate must still leave four cycles per bit
    localparam int unsigned DIV = 48;
    logic sys_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    spf_cfg_t cfg = '0;
    logic [7:0] tx_data = 8'h00;
    logic tx_valid = 1'b0;
    logic rx_ready = 1'b0;
    logic rxd, txd, txd_oe, tx_ready, rx_valid;
    logic par_err, frm_err, ovr_err, paused, addressed;
    logic [7:0] rx_data;
    int n_fail = 0;
    int checks = 0;
    int n_ovr = 0;
    int n_perr = 0;
    int n_stall = 0;
    int fac[5] = '{1, 2, 4, 6, 12};

    always #5 sys_clk_i = ~sys_clk_i;

    spf_serial_port #(.SECOND_PORT(1'b1), .DIV_9600(DIV)) uut (
        .sys_clk_i(sys_clk_i),
        .arst_n_i(arst_n_i),
        .ce_i(1'b1),
        .cfg_i(cfg),
        .rxd_i(rxd),
        .txd_o(txd),
        .txd_oe_o(txd_oe),
        .tx_data_i(tx_data),
        .tx_valid_i(tx_valid),
        .tx_ready_o(tx_ready),
        .rx_data_o(rx_data),
        .rx_valid_o(rx_valid),
        .rx_ready_i(rx_ready),
        .rx_par_err_o(par_err),
        .rx_frm_err_o(frm_err),
        .rx_ovr_err_o(ovr_err),
        .tx_paused_o(paused),
        .addressed_o(addressed)
    );

    spf_host host (
        .sys_clk_i(sys_clk_i),
        .txd_i(txd),
        .txd_oe_i(txd_oe),
        .rxd_o(rxd)
    );

    // pulses last one cycle, so the falling edge sees each exactly once
    always @(negedge sys_clk_i) begin
        if (ovr_err === 1'b1) n_ovr++;
        if (par_err === 1'b1 || frm_err === 1'b1) n_perr++;
        if (tx_valid === 1'b1 && tx_ready === 1'b0) n_stall++;
    end

    task automatic stop_test;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : stop_test

    task automatic fail(input string msg);
        n_fail++;
        $display("[ERR] %0t %s", $time, msg);
        stop_test();
    endtask : fail

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // valid held until ready is seen ahead of the taking edge
    task automatic push(input logic [7:0] d);
        int n;
        @(negedge sys_clk_i);
        tx_data = d;
        tx_valid = 1'b1;
        for (n = 0; n < 2000 && tx_ready !== 1'b1; n++) @(negedge sys_clk_i);
        if (n == 2000) fail("tx buffer never ready");
        @(negedge sys_clk_i);
        tx_valid = 1'b0;
    endtask : push

    task automatic get(input logic [7:0] exp);
        int n;
        for (n = 0; n < 4000 && host.rx_q.size() == 0; n++) begin
            @(negedge sys_clk_i);
        end
        if (n == 4000) fail("no character on line");
        chk(host.rx_q.pop_front(), exp);
    endtask : get

    task automatic pop(input logic [7:0] exp);
        int n;
        for (n = 0; n < 4000 && rx_valid !== 1'b1; n++) @(negedge sys_clk_i);
        if (n == 4000) fail("no received word");
        chk(rx_data, exp);
        rx_ready = 1'b1;
        @(negedge sys_clk_i);
        rx_ready = 1'b0;
        @(negedge sys_clk_i);
    endtask : pop

    initial begin
        host.div = int'(DIV);
        repeat (5) @(negedge sys_clk_i);
        chk({7'h0, txd}, 8'h01);
        chk({7'h0, tx_ready}, 8'h01);
        chk({7'h0, rx_valid}, 8'h00);
        arst_n_i = 1'b1;
        repeat (3) @(negedge sys_clk_i);
        chk({7'h0, txd_oe}, 8'h01);
        push(8'ha5);
        get(8'ha5);
        // an unread word makes the port throttle its peer
        host.send(8'h3c);
        get(SPF_XOFF);
        pop(8'h3c);
        get(SPF_XON);
        // peer throttles the port; the held word goes after the release
        host.send(SPF_XOFF);
        repeat (3) @(negedge sys_clk_i);
        chk({7'h0, paused}, 8'h01);
        chk({7'h0, rx_valid}, 8'h00);
        push(8'h55);
        repeat (600) @(negedge sys_clk_i);
        chk(8'(host.rx_q.size()), 8'h00);
        host.send(SPF_XON);
        repeat (3) @(negedge sys_clk_i);
        chk({7'h0, paused}, 8'h00);
        get(8'h55);
        // every rate and parity code, both directions at once
        cfg.flow_off = 1'b1;
        for (int i = 0; i < 5; i++) begin
            cfg.baud_sel = 3'(i);
            cfg.parity = 2'(i % 3);
            host.div = int'(DIV) / fac[i];
            host.par = cfg.parity;
            fork
                push(8'h30 + 8'(i));
                host.send(8'hc0 + 8'(i));
            join
            get(8'h30 + 8'(i));
            pop(8'hc0 + 8'(i));
        end
        chk(8'(n_perr), 8'h00);
        chk(8'(host.n_frm), 8'h00);
        cfg.baud_sel = 3'h0;
        host.div = int'(DIV);
        // a wrong parity bit is flagged, the character still delivered
        cfg.parity = SPF_PAR_EVEN;
        host.par = SPF_PAR_ODD;
        host.send(8'h5a);
        repeat (3) @(negedge sys_clk_i);
        chk(8'(n_perr), 8'h01);
        pop(8'h5a);
        cfg.parity = 2'h0;
        host.par = 2'h0;
        // transmit buffer fills up, then drains in order
        n_stall = 0;
        for (int i = 0; i < 4; i++) push(8'h60 + 8'(i));
        chk({7'h0, n_stall != 0}, 8'h01);
        for (int i = 0; i < 4; i++) get(8'h60 + 8'(i));
        // a third word with the receive buffer full is dropped
        n_ovr = 0;
        for (int i = 0; i < 3; i++) host.send(8'h70 + 8'(i));
        repeat (3) @(negedge sys_clk_i);
        chk(8'(n_ovr), 8'h01);
        pop(8'h70);
        pop(8'h71);
        chk({7'h0, rx_valid}, 8'h00);
        // shared bus: silent until its own address is heard
        cfg.half_duplex = 1'b1;
        cfg.addr_en = 1'b1;
        cfg.bus_addr = 8'h42;
        repeat (3) @(negedge sys_clk_i);
        chk({7'h0, txd_oe}, 8'h00);
        push(8'h77);
        repeat (600) @(negedge sys_clk_i);
        chk(8'(host.rx_q.size()), 8'h00);
        host.send(8'h42);
        repeat (3) @(negedge sys_clk_i);
        chk({7'h0, addressed}, 8'h01);
        chk({7'h0, rx_valid}, 8'h00);
        get(8'h77);
        repeat (30) @(negedge sys_clk_i);
        chk({7'h0, addressed}, 8'h00);
        chk({7'h0, txd_oe}, 8'h00);
        stop_test();
    end
endmodule : testbench
